// [design/pwc_pkg.sv]
// Purpose: Shared constants and types for the capture and pulse generator channel
// Assumes: 32-bit classic Wishbone register bus, byte addresses word aligned
// Notes: Registers hold narrow data in the low bits; upper bits read as zero
package pwc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_A_LO = 8'h08;
  localparam logic [7:0] OFF_A_HI = 8'h0c;
  localparam logic [7:0] OFF_B_LO = 8'h10;
  localparam logic [7:0] OFF_B_HI = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_A_WORD = 8'h1c;
  localparam logic [7:0] OFF_B_WORD = 8'h20;

  // Operating mode codes
  localparam logic [2:0] OP_PWM = 3'h6;
  localparam logic [2:0] OP_PPG = 3'h3;

  // Reset and counter values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] CC_RST = 16'h0000;
  localparam logic [15:0] CNT_CLEAR = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // Mode register layout: bit 7 capture style, 6 edge, 5:3 clock select, 2:0 mode
  typedef struct packed {
    logic cap_single;
    logic edge_fall;
    logic [2:0] clk_sel;
    logic [2:0] op;
  } mode_t;

  // Control register layout: bit 4 double buffer, 3 idle level, 2 one-shot, 1 ovf irq, 0 run
  typedef struct packed {
    logic dbf;
    logic tff;
    logic one_shot;
    logic ove;
    logic run;
  } ctrl_t;

  // Status register layout: bit 2 overflow, 1 capture B, 0 capture A
  typedef struct packed {
    logic ovf;
    logic cpfb;
    logic cpfa;
  } stat_t;

  typedef enum logic [1:0] {
    MEAS_WAIT = 2'b00,
    MEAS_PULSE = 2'b01,
    MEAS_GAP = 2'b10
  } meas_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic pin_prev;
    logic [7:0] presc;
    mode_t mode;
    ctrl_t ctrl;
    stat_t stat;
    logic [15:0] cnt;
    logic [15:0] cc_a;
    logic [15:0] cc_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [7:0] tmp;
    meas_t meas;
    logic pulse_out;
    logic irq;
    logic ack;
    logic [31:0] rdat;
  } state_t;

endpackage : pwc_pkg

// [design/pulse_width_capture_ppg_timer.sv]
// Purpose: 16-bit channel with pulse width capture and programmable pulse output
// Assumes: Single clock; timer input pin is asynchronous and is synchronised here
// Notes: Channel interrupt is a one-cycle pulse; only the overflow interrupt is masked here, by overflow enable
`timescale 1ns/1ns

// Functional notes
// - Mode code 110 selects pulse width capture, counting on the chosen source clock.
// - Edge bit 0 starts on rising edge, 1 starts on falling edge.
// - Capture style 0 is double-edge, 1 is single-edge.
// - Overflow raises the interrupt only when overflow enable is set.
// - Starting in capture mode zeroes both capture registers.
// - Mode register and overflow enable are frozen while running.
// - Start edge interrupts and counts; opposite edge captures B, interrupts, flags B.
// - Double-edge: next start edge captures A, interrupts, flags A, clears counter.
// - Single-edge: opposite edge stops and clears counter; start edge resumes with interrupt.
// - Overflow while capturing sets overflow flag; interrupts if enabled.
// - Reading status clears both capture flags and the overflow flag.
// - Clearing run stops the counter and zeroes it.
// - An opposite edge first after start is ignored without interrupt.
// - Mode code 011 selects pulse output, continuous or one-shot.
// - Idle level bit sets output idle level; frozen while running.
// - Match on B drives output to opposite level, counting continues.
// - Match on A restores level, interrupts; one-shot stops, else counter restarts.
// - One-shot bit may change while running; takes effect at pulse end.
// - Low byte waits in a temporary buffer until the high byte write.
// - Double buffer defers running writes to the A match; reads show buffer.
module pulse_width_capture_ppg_timer
  import pwc_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and event
  input wire logic timer_input_pin_i,
  output logic pulse_output_pin_o,
  output logic channel_interrupt_o
);

  localparam state_t RST_STATE = '{
    sync1: 1'b0, sync2: 1'b0, pin_prev: 1'b0, presc: 8'h00,
    mode: MODE_RST, ctrl: CTRL_RST, stat: 3'h0, cnt: CNT_CLEAR,
    cc_a: CC_RST, cc_b: CC_RST, buf_a: CC_RST, buf_b: CC_RST,
    tmp: 8'h00, meas: MEAS_WAIT, pulse_out: 1'b0, irq: 1'b0,
    ack: 1'b0, rdat: 32'h0000_0000
  };

  state_t s;
  state_t n;
  logic tick;
  logic start_e;
  logic opp_e;
  logic req;
  logic pwm_run;
  logic ppg_run;
  stat_t stat_set;
  stat_t stat_clr;
  logic [15:0] wval;
  logic [31:0] cc_pair;
  logic [15:0] view_a;
  logic [15:0] view_b;

  // Prescaler tap: source clock is the system clock divided by two to the select
  function automatic logic tick_of(input logic [7:0] presc, input logic [2:0] sel);
    logic [7:0] mask;
    mask = ~(8'hff << sel);
    return (presc & mask) == mask;
  endfunction : tick_of

  // Returns active value in the high half and buffered value in the low half
  function automatic logic [31:0] cc_write(input logic [15:0] act, input logic [15:0] val,
                                           input logic run, input logic dbf);
    if (!run) begin
      return {val, val};
    end else if (dbf) begin
      return {act, val};
    end else begin
      return {val, val};
    end
  endfunction : cc_write

  function automatic logic [15:0] cc_view(input logic [15:0] act, input logic [15:0] bufv,
                                          input logic dbf);
    return dbf ? bufv : act;
  endfunction : cc_view

  assign tick = tick_of(s.presc, s.mode.clk_sel);
  assign start_e = s.mode.edge_fall ? (s.pin_prev & ~s.sync2) : (~s.pin_prev & s.sync2);
  assign opp_e = s.mode.edge_fall ? (~s.pin_prev & s.sync2) : (s.pin_prev & ~s.sync2);
  assign req = wb_cyc_i & wb_stb_i;
  assign pwm_run = s.ctrl.run & (s.mode.op == OP_PWM);
  assign ppg_run = s.ctrl.run & (s.mode.op == OP_PPG);
  assign view_a = cc_view(s.cc_a, s.buf_a, s.ctrl.dbf);
  assign view_b = cc_view(s.cc_b, s.buf_b, s.ctrl.dbf);

  always_comb begin
    n = s;
    stat_set = 3'h0;
    stat_clr = 3'h0;
    wval = {wb_dat_i[7:0], s.tmp};
    cc_pair = 32'h0000_0000;
    // First stage feeds only the second; edges use the second and third
    n.sync1 = timer_input_pin_i;
    n.sync2 = s.sync1;
    n.pin_prev = s.sync2;
    n.presc = s.presc + 8'h01;
    n.irq = 1'b0;
    n.ack = 1'b0;

    if (pwm_run) begin
      case (s.meas)
        MEAS_WAIT: begin
          if (start_e) begin
            n.irq = 1'b1;
            n.cnt = CNT_CLEAR;
            n.meas = MEAS_PULSE;
          end
        end
        MEAS_PULSE: begin
          if (opp_e) begin
            n.cc_b = s.cnt;
            n.buf_b = s.cnt;
            n.irq = 1'b1;
            stat_set.cpfb = 1'b1;
            if (s.mode.cap_single) begin
              n.cnt = CNT_CLEAR;
              n.meas = MEAS_WAIT;
            end else begin
              n.meas = MEAS_GAP;
            end
          end
        end
        MEAS_GAP: begin
          if (start_e) begin
            n.cc_a = s.cnt;
            n.buf_a = s.cnt;
            n.irq = 1'b1;
            stat_set.cpfa = 1'b1;
            n.cnt = CNT_CLEAR;
            n.meas = MEAS_PULSE;
          end
        end
        default: begin
          n.meas = MEAS_WAIT;
        end
      endcase
      // Counting continues through the opposite edge only in double-edge style
      if (tick && (s.meas != MEAS_WAIT) && !(opp_e && s.mode.cap_single && s.meas == MEAS_PULSE)
          && !(start_e && s.meas == MEAS_GAP)) begin
        n.cnt = s.cnt + 16'h0001;
        if (s.cnt == CNT_MAX) begin
          stat_set.ovf = 1'b1;
          if (s.ctrl.ove) begin
            n.irq = 1'b1;
          end
        end
      end
    end else if (ppg_run && tick) begin
      if (s.cnt == s.cc_a) begin
        n.pulse_out = s.ctrl.tff;
        n.irq = 1'b1;
        n.cnt = CNT_CLEAR;
        if (s.ctrl.dbf) begin
          n.cc_a = s.buf_a;
          n.cc_b = s.buf_b;
        end
        if (s.ctrl.one_shot) begin
          n.ctrl.run = 1'b0;
        end
      end else begin
        if (s.cnt == s.cc_b) begin
          n.pulse_out = ~s.ctrl.tff;
        end
        // A compare below the count is only met again after the wrap
        n.cnt = s.cnt + 16'h0001;
      end
    end

    // Bus access: read data is sampled on the request edge; write data and effects land on the ack edge
    if (req && !s.ack) begin
      n.ack = 1'b1;
      n.rdat = 32'h0000_0000;
      case (wb_adr_i)
        OFF_MODE: n.rdat[7:0] = s.mode;
        OFF_CTRL: n.rdat[4:0] = s.ctrl;
        OFF_A_LO: n.rdat[7:0] = view_a[7:0];
        OFF_A_HI: n.rdat[7:0] = view_a[15:8];
        OFF_B_LO: n.rdat[7:0] = view_b[7:0];
        OFF_B_HI: n.rdat[7:0] = view_b[15:8];
        OFF_STAT: n.rdat[2:0] = s.stat;
        OFF_A_WORD: n.rdat[15:0] = view_a;
        OFF_B_WORD: n.rdat[15:0] = view_b;
        default: n.rdat = 32'h0000_0000;
      endcase
    end

    if (req && s.ack && !wb_we_i && wb_adr_i == OFF_STAT) begin
      stat_clr = s.rdat[2:0];
    end

    if (req && s.ack && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        OFF_MODE: begin
          if (!s.ctrl.run) begin
            n.mode = wb_dat_i[7:0];
          end
        end
        OFF_CTRL: begin
          n.ctrl.run = wb_dat_i[0];
          n.ctrl.one_shot = wb_dat_i[2];
          n.ctrl.dbf = wb_dat_i[4];
          if (!s.ctrl.run) begin
            n.ctrl.ove = wb_dat_i[1];
            n.ctrl.tff = wb_dat_i[3];
            if (wb_dat_i[0]) begin
              n.pulse_out = wb_dat_i[3];
              n.cnt = CNT_CLEAR;
              n.meas = MEAS_WAIT;
              if (s.mode.op == OP_PWM) begin
                n.cc_a = CC_RST;
                n.cc_b = CC_RST;
                n.buf_a = CC_RST;
                n.buf_b = CC_RST;
              end
            end
          end
        end
        OFF_A_LO, OFF_B_LO: begin
          n.tmp = wb_dat_i[7:0];
        end
        OFF_A_HI: begin
          cc_pair = cc_write(n.cc_a, wval, s.ctrl.run, s.ctrl.dbf);
          n.cc_a = cc_pair[31:16];
          n.buf_a = cc_pair[15:0];
        end
        OFF_B_HI: begin
          cc_pair = cc_write(n.cc_b, wval, s.ctrl.run, s.ctrl.dbf);
          n.cc_b = cc_pair[31:16];
          n.buf_b = cc_pair[15:0];
        end
        default: begin
          n.tmp = s.tmp;
        end
      endcase
    end

    // A flag raised in the clearing cycle survives the clear
    n.stat = (s.stat & ~stat_clr) | stat_set;

    if (!n.ctrl.run) begin
      n.cnt = CNT_CLEAR;
      n.meas = MEAS_WAIT;
      n.pulse_out = n.ctrl.tff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RST_STATE;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign pulse_output_pin_o = s.pulse_out;
  assign channel_interrupt_o = s.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_zeroes_caps:
  assert property ($rose(s.ctrl.run) && s.mode.op == OP_PWM |-> s.cc_a == CC_RST && s.cc_b == CC_RST)
    else $error("Capture registers not zeroed at start");

  a_mode_frozen_run:
  assert property (s.ctrl.run && $past(s.ctrl.run) |-> $stable(s.mode) && $stable(s.ctrl.ove))
    else $error("Mode or overflow enable changed while running");

  a_capture_b_edge:
  assert property (ce_i && pwm_run && s.meas == MEAS_PULSE && opp_e
                   |=> s.irq && s.stat.cpfb && s.cc_b == $past(s.cnt))
    else $error("Opposite edge did not capture into B");

  a_capture_a_edge:
  assert property (ce_i && pwm_run && s.meas == MEAS_GAP && start_e
                   |=> s.irq && s.stat.cpfa && s.cc_a == $past(s.cnt) && s.cnt == CNT_CLEAR)
    else $error("Start edge did not capture into A");

  a_single_stops:
  assert property (ce_i && pwm_run && s.mode.cap_single && s.meas == MEAS_PULSE && opp_e
                   |=> s.cnt == CNT_CLEAR && s.meas == MEAS_WAIT ##1 (s.cnt == CNT_CLEAR || !ce_i
                   || s.meas != MEAS_WAIT || $past(start_e) || !s.ctrl.run))
    else $error("Single-edge capture kept counting");

  a_overflow_flag:
  assert property (ce_i && pwm_run && tick && s.meas != MEAS_WAIT && s.cnt == CNT_MAX
                   && !opp_e && !start_e |=> s.stat.ovf && (s.irq == $past(s.ctrl.ove)))
    else $error("Overflow not flagged as enabled");

  a_first_opp_quiet:
  assert property (ce_i && pwm_run && s.meas == MEAS_WAIT && opp_e |=> !s.irq && s.meas == MEAS_WAIT)
    else $error("Opposite edge before start edge acted");

  a_stop_restores:
  assert property ($fell(s.ctrl.run) |-> s.cnt == CNT_CLEAR && s.pulse_out == s.ctrl.tff)
    else $error("Stop did not clear counter or restore level");

  a_b_match_flips:
  assert property (ce_i && ppg_run && tick && s.cnt == s.cc_b && s.cnt != s.cc_a
                   |=> s.pulse_out == ~s.ctrl.tff || !s.ctrl.run)
    else $error("Compare B match did not invert output");

  a_a_match_ends:
  assert property (ce_i && ppg_run && tick && s.cnt == s.cc_a
                   |=> s.irq && s.pulse_out == s.ctrl.tff && s.cnt == CNT_CLEAR)
    else $error("Compare A match did not end the pulse");

  a_idle_level:
  assert property (!s.ctrl.run |-> s.pulse_out == s.ctrl.tff)
    else $error("Stopped output not at idle level");

  a_start_level:
  assert property ($rose(s.ctrl.run) && s.mode.op == OP_PPG |-> s.pulse_out == s.ctrl.tff)
    else $error("Pulse output did not start at idle level");

  a_status_clears:
  assert property (ce_i && req && s.ack && !wb_we_i && wb_adr_i == OFF_STAT
                   |=> s.irq || !$past(s.ctrl.ove) || (s.stat & $past(s.rdat[2:0])) == 3'h0)
    else $error("Status read did not clear returned flags");

endmodule : pulse_width_capture_ppg_timer

// [verification/pulse_src.sv]
// Purpose: Pulse source that drives the timer input pin
// Assumes: Called from the bench just after a rising clock edge
// Notes: The pin carries no pull, so it always holds a driven level
`timescale 1ns/1ns
module pulse_src (
  // Clock
  input wire logic clk_i,
  // Pin
  output logic pin_o
);
  initial pin_o = 1'b0;
  // Widths stay well above the synchroniser delay of the device
  task automatic drive(input logic lvl, input int n);
    pin_o <= lvl;
    repeat (n) @(posedge clk_i);
  endtask : drive
endmodule : pulse_src

// [verification/pulse_width_capture_ppg_timer_tb.sv]
// Purpose: Self-checking bench for the capture and pulse generator channel
// Assumes: Source clock select 0 except the double-edge run, which divides by four
// Notes: Capture values allow one count of slack for input latency
`timescale 1ns/1ns
module pulse_width_capture_ppg_timer_tb;
  import pwc_pkg::*;
  typedef struct {string n; logic [31:0] lo; logic [31:0] hi;} note_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] r;
  logic [31:0] seed = 32'hc386;
  logic ack, pin, ppg, irq;
  note_t notes[$];
  note_t cur;
  int miscompares = 0;
  int compares = 0;
  int irqs = 0;
  int hi_cnt = 0;
  int cycles = 0;
  int base, hb;

  always #5 clk_i = ~clk_i;

  pulse_width_capture_ppg_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timer_input_pin_i(pin),
    .pulse_output_pin_o(ppg), .channel_interrupt_o(irq));
  pulse_src i_src (.clk_i(clk_i), .pin_o(pin));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic fail(input string n, input logic [31:0] e, input logic [31:0] g);
    miscompares++;
    $display("CHECK FAILED %s expected %h seen %h", n, e, g);
  endtask : fail

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) fail(n, e, g);
  endtask : chk

  task automatic final_report();
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // Request held until ack is sampled high, then released for one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] lo,
                    input logic [31:0] hi);
    notes.push_back('{n, lo, hi});
    wb(1'b0, a, 8'h00);
  endtask : rd

  // Watcher: read data is judged in the cycle its ack stands
  always @(posedge clk_i) begin
    cycles++;
    if (irq === 1'b1) irqs++;
    if (ppg === 1'b1) hi_cnt++;
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      cur = notes.pop_front();
      compares++;
      if ((rdat >= cur.lo && rdat <= cur.hi) !== 1'b1) fail(cur.n, cur.lo, rdat);
    end
    if (cycles == 75000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("mode", OFF_MODE, 0, 0);
    rd("ctrl", OFF_CTRL, 0, 0);
    rd("unmapped", 8'h30, 0, 0);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      wb(1'b1, i[0] ? OFF_B_LO : OFF_A_LO, r[7:0]);
      wb(1'b1, i[0] ? OFF_B_HI : OFF_A_HI, r[15:8]);
      rd("word", i[0] ? OFF_B_WORD : OFF_A_WORD, r[15:0], r[15:0]);
    end
    // Period 20, first toggle at 8: compare A kept above B
    wb(1'b1, OFF_A_LO, 8'd20);
    wb(1'b1, OFF_A_HI, 8'h00);
    wb(1'b1, OFF_B_LO, 8'd8);
    wb(1'b1, OFF_B_HI, 8'h00);
    wb(1'b1, OFF_MODE, {5'h00, OP_PPG});
    base = irqs;
    hb = hi_cnt;
    wb(1'b1, OFF_CTRL, 8'h05);
    wb(1'b1, OFF_MODE, 8'h00);
    wb(1'b1, OFF_CTRL, 8'h0d);
    repeat (30) @(posedge clk_i);
    chk("high", 12, hi_cnt - hb);
    chk("irq", 1, irqs - base);
    chk("pin", 0, ppg);
    rd("mode", OFF_MODE, 3, 3);
    rd("ctrl", OFF_CTRL, 4, 4);
    base = irqs;
    wb(1'b1, OFF_CTRL, 8'h19);
    chk("start", 1, ppg);
    wb(1'b1, OFF_A_LO, 8'd40);
    wb(1'b1, OFF_A_HI, 8'h00);
    rd("abuf", OFF_A_WORD, 40, 40);
    // Let the old period of 20 end so the buffered 40 becomes active
    repeat (20) @(posedge clk_i);
    wb(1'b1, OFF_CTRL, 8'h0d);
    rd("aact", OFF_A_WORD, 40, 40);
    repeat (40) @(posedge clk_i);
    rd("ctrl", OFF_CTRL, 12, 12);
    chk("irq", 2, irqs - base);
    wb(1'b1, OFF_CTRL, 8'h18);
    @(posedge clk_i);
    chk("idle", 1, ppg);
    // Double-edge capture, rising start, opposite edge seen first, count clock divided by four
    wb(1'b1, OFF_MODE, {2'b00, 3'h2, OP_PWM});
    i_src.drive(1'b1, 10);
    wb(1'b1, OFF_CTRL, 8'h03);
    rd("a0", OFF_A_WORD, 0, 0);
    base = irqs;
    i_src.drive(1'b0, 20);
    i_src.drive(1'b1, 10);
    // Enable low for five cycles takes five clocks off both captured widths
    ce <= 1'b0;
    i_src.drive(1'b1, 5);
    ce <= 1'b1;
    i_src.drive(1'b1, 15);
    i_src.drive(1'b0, 40);
    i_src.drive(1'b1, 20);
    rd("stat", OFF_STAT, 3, 3);
    rd("stat", OFF_STAT, 0, 0);
    rd("capb", OFF_B_WORD, 5, 7);
    rd("capa", OFF_A_WORD, 15, 17);
    chk("irq", 3, irqs - base);
    // Single-edge capture, falling start, long enough to wrap once
    wb(1'b1, OFF_CTRL, 8'h00);
    wb(1'b1, OFF_MODE, {2'b11, 3'h0, OP_PWM});
    wb(1'b1, OFF_CTRL, 8'h03);
    base = irqs;
    i_src.drive(1'b0, 66000);
    i_src.drive(1'b1, 10);
    i_src.drive(1'b0, 10);
    rd("stat", OFF_STAT, 6, 6);
    rd("capb", OFF_B_WORD, 463, 465);
    chk("irq", 4, irqs - base);
    wb(1'b1, OFF_CTRL, 8'h00);
    // Second reset: mode and control must return to their reset values
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("rst mode", OFF_MODE, 0, 0);
    rd("rst ctrl", OFF_CTRL, 0, 0);
    final_report();
  end
endmodule : pulse_width_capture_ppg_timer_tb
